/* File: dv/general_timer_time_base_test.sv */
/*
 self-checking bench for the timer time-base unit.
 assumes nothing of bus latency: waits on waitrequest; byte lanes all enabled.
*/
`include "timer_map.vh"
module general_timer_time_base_test;
timeunit 1ns;
timeprecision 1ps;
logic clk_sys = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
logic [5:0] avs_address = 6'h0;
logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
logic [3:0] avs_byteenable = 4'hf;
logic avs_waitrequest, update_request, update_event;
logic [1:0] avs_response, rsp;
int mismatches = 0, comparisons = 0, cycles = 0, events = 0, requests = 0, p;
general_timer_time_base dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.avs_response(avs_response), .update_request(update_request), .update_event(update_event));
always #4 clk_sys = ~clk_sys;
always @(negedge clk_sys)
begin
	events += (update_event === 1'b1);
	requests += (update_request === 1'b1);
end
always @(posedge clk_sys)
begin
	cycles++;
	// whole run is a few hundred cycles
	if (cycles == 5000)
	begin
		mismatches++;
		final_report;
	end
end
task final_report;
	if (mismatches == 0 && comparisons > 0)
		$display("TB: PASS");
	else
		$display("TB: FAIL");
	$finish;
endtask
task chk(input string n, input logic [31:0] e, input logic [31:0] s);
	comparisons++;
	if (s !== e)
	begin
		mismatches++;
		$display("[FAIL] %s exp %h got %h", n, e, s);
	end
endtask
// called just after a rising edge; answer taken at the edge that shows it
task acc(input logic w, input logic [3:0] i, input logic [31:0] d);
	avs_read <= !w;
	avs_write <= w;
	avs_address <= {i, 2'h0};
	avs_writedata <= d;
	do
		@(posedge clk_sys);
	while (avs_waitrequest !== 1'b0);
	q = avs_readdata;
	rsp = avs_response;
	avs_read <= 1'b0;
	avs_write <= 1'b0;
	@(posedge clk_sys);
endtask
// cycles between two update events
task period;
	while (update_event !== 1'b1)
		@(posedge clk_sys);
	p = 0;
	do
	begin
		@(posedge clk_sys);
		p++;
	end
	while (update_event !== 1'b1);
endtask
task t_regs;
	acc(0, `ADDR_COUNT, 0); chk("count", 32'h0, q);
	acc(1, `ADDR_RELOAD, 32'h3);
	acc(0, `ADDR_RELOAD_ACTIVE, 0); chk("shadow", 32'h3, q);
	acc(0, 4'h9, 0); chk("resp", 32'h2, rsp);
	acc(0, `ADDR_EVENT, 0); chk("event", 32'h0, q);
	acc(1, `ADDR_COUNT, 32'h2);
	acc(0, `ADDR_COUNT, 0); chk("count", 32'h2, q);
endtask
task t_up;
	acc(1, `ADDR_CONTROL, 32'h1);
	period; chk("up", 32'h4, p);
	acc(1, `ADDR_CONTROL, 32'h0);
	acc(1, `ADDR_PRESCALE, 32'h1);
	acc(0, `ADDR_PRESCALE_ACTIVE, 0); chk("psc", 32'h0, q);
	acc(1, `ADDR_CONTROL, 32'h1);
	period; chk("scaled", 32'h8, p);
	acc(0, `ADDR_STATUS, 0); chk("flag", 32'h1, q);
endtask
task t_down;
	acc(1, `ADDR_CONTROL, 32'h90);
	acc(1, `ADDR_RELOAD, 32'h5);
	acc(0, `ADDR_RELOAD_ACTIVE, 0); chk("shadow", 32'h3, q);
	acc(1, `ADDR_CONTROL, 32'h91);
	period; chk("down", 32'hc, p);
	acc(1, `ADDR_CONTROL, 32'h83);
	events = 0;
	repeat (60) @(posedge clk_sys);
	chk("masked", 32'h0, events);
endtask
task t_generate;
	acc(1, `ADDR_CONTROL, 32'h4);
	acc(1, `ADDR_STATUS, 32'h0);
	events = 0;
	requests = 0;
	acc(1, `ADDR_EVENT, 32'h1);
	repeat (3) @(posedge clk_sys);
	chk("gen", 32'h1, events);
	chk("quiet", 32'h0, requests);
	acc(0, `ADDR_STATUS, 0); chk("flag", 32'h0, q);
	acc(0, `ADDR_COUNT, 0); chk("count", 32'h0, q);
	acc(1, `ADDR_CONTROL, 32'h0);
	acc(1, `ADDR_EVENT, 32'h1);
	repeat (3) @(posedge clk_sys);
	chk("req", 32'h1, requests);
	acc(0, `ADDR_STATUS, 0); chk("flag", 32'h1, q);
endtask
initial
begin
	repeat (6) @(posedge clk_sys);
	sys_rst <= 1'b0;
	t_regs;
	t_up;
	t_down;
	t_generate;
	final_report;
end
endmodule

/* File: dv/timer_base_monitor.sv */
/*
 port checks on the timer time-base unit.
 assumes one clock and a synchronous active-high reset.
*/
module timer_base_monitor (
	input logic clk_sys,
	input logic sys_rst,
	input logic [5:0] avs_address,
	input logic avs_read,
	input logic avs_write,
	input logic [31:0] avs_writedata,
	input logic [3:0] avs_byteenable,
	input logic [31:0] avs_readdata,
	input logic avs_waitrequest,
	input logic [1:0] avs_response,
	input logic update_request,
	input logic update_event
);
default clocking @(posedge clk_sys); endclocking
default disable iff (sys_rst);
AST_ONE_WAIT: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
	else $error("wait low too long");
AST_ACK_CAUSE: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
	else $error("ack without request");
AST_BAD_ADDR: assert property (!avs_waitrequest && avs_address[5] |-> avs_response == 2'h2)
	else $error("unmapped not refused");
AST_GOOD_ADDR: assert property (!avs_waitrequest && !avs_address[5] |-> avs_response == 2'h0)
	else $error("mapped refused");
AST_EVENT_ZERO: assert property (!avs_waitrequest && avs_read && avs_address[5:2] == 4'h2
	|-> avs_readdata == 32'h0) else $error("event reg not zero");
AST_GEN_EVENT: assert property (!avs_waitrequest && avs_write && avs_address[5:2] == 4'h2
	&& avs_writedata[0] && avs_byteenable[0] |-> ##[1:2] update_event) else $error("no event");
AST_REQ_EVENT: assert property (update_request |-> update_event)
	else $error("request without event");
AST_READ_HOLD: assert property (avs_waitrequest && !(avs_read || avs_write)
	|=> $stable(avs_readdata)) else $error("read data moved");
endmodule
bind general_timer_time_base timer_base_monitor mon_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.avs_response(avs_response), .update_request(update_request), .update_event(update_event));

/* File: hdl/count_core.v */
/*
 main counter core: up or down counting with wrap detection.
 assumes tick is a one-cycle counter clock enable.
*/
module count_core #(
	parameter WIDTH = 32
) (
	input wire clk_sys,
	input wire sys_rst,
	input wire tick,
	input wire down,
	input wire clear,
	input wire [WIDTH-1:0] limit,
	input wire [WIDTH-1:0] next_limit,
	input wire write_en,
	input wire [WIDTH-1:0] write_data,
	output reg [WIDTH-1:0] count,
	output wire wrap
);
	// halted while the active reload is zero
	wire live = tick && (limit != {WIDTH{1'b0}});
	assign wrap = live && (down ? (count == {WIDTH{1'b0}}) : (count >= limit));
	always @(posedge clk_sys)
	begin
		if (sys_rst)
			count <= {WIDTH{1'b0}};
		else if (clear)
			count <= down ? next_limit : {WIDTH{1'b0}};
		else if (write_en)
			count <= write_data;
		else if (wrap)
			count <= down ? next_limit : {WIDTH{1'b0}};
		else if (live)
			count <= down ? count - 1'b1 : count + 1'b1;
	end
endmodule

/* File: hdl/general_timer_time_base.v */
/*
 time-base unit of a general-purpose timer, avalon-mm slave.
 assumes one clock, synchronous reset, master holds requests until waitrequest low.
*/
// Behaviour
// - 32-bit counter with auto-reload, counting up or down.
// - prescaler divides counter clock by 1 to 65536 from a 16-bit setting.
// - prescaler setting buffered, applied at next update event.
// - counter, reload and prescaler readable and writable while running.
// - software reload accesses hit the preload; counter uses the shadow.
// - preload-enable clear copies reload at once; set copies on update.
// - overflow or underflow gives update event only while update disabled is 0.
// - counter advances only on prescaled clock, gated by counter enable.
// - up mode counts 0 to reload, wraps to 0, overflow.
// - update-generate bit forces an update event.
// - updates disabled up mode: counter and divider restart, ratio unchanged.
// - updates disabled down mode: reload current value, divider restarts.
// - request select set: generated update sets no flag or request.
// - update loads prescaler buffer and reload shadow; sets flag unless suppressed.
// - down mode counts reload to 0, reloads, underflow.
// - shadow and counter reload take the new reload on the same edge so next period uses it.
// - update events can raise an interrupt or dma request.
// - counter halted while active reload is zero.
// - enable, direction, generate software-only; generate clears itself.
`include "timer_map.vh"
module general_timer_time_base #(
	parameter CNT_WIDTH = 32,
	parameter PSC_WIDTH = 16
) (
	input wire clk_sys,
	input wire sys_rst,
	input wire [5:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	output reg [1:0] avs_response,
	output reg update_request,
	output reg update_event
);
	reg [7:0] control_register_one;
	reg update_flag;
	reg [PSC_WIDTH-1:0] prescaler_value;
	reg [CNT_WIDTH-1:0] auto_reload_value;
	reg [CNT_WIDTH-1:0] reload_active;
	reg update_generate;
	reg gen_quiet;
	reg ack;
	wire [PSC_WIDTH-1:0] prescale_active;
	wire [CNT_WIDTH-1:0] counter_value;
	wire tick;
	wire wrap;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0] be;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (be[i])
					merge[i*8 +: 8] = data[i*8 +: 8];
		end
	endfunction

	wire [3:0] index = avs_address[5:2];
	wire req = (avs_read || avs_write) && !ack;
	wire wr = avs_write && !ack;
	wire counter_enable_bit = control_register_one[`BIT_ENABLE];
	wire update_disable = control_register_one[`BIT_UPDATE_DISABLE];
	wire update_request_select = control_register_one[`BIT_REQUEST_SELECT];
	wire down = control_register_one[`BIT_DOWN];
	wire reload_preload_enable = control_register_one[`BIT_RELOAD_PRELOAD];
	wire wrap_update = wrap && !update_disable;
	wire any_update = wrap_update || update_generate;
	wire set_flag = wrap_update || (update_generate && !gen_quiet);
	wire [CNT_WIDTH-1:0] reload_next = (any_update || !reload_preload_enable)
		? auto_reload_value : reload_active;
	wire [31:0] cnt_word = merge({{(32-CNT_WIDTH){1'b0}}, counter_value}, avs_writedata,
		avs_byteenable);
	wire [31:0] arr_word = merge({{(32-CNT_WIDTH){1'b0}}, auto_reload_value}, avs_writedata,
		avs_byteenable);
	wire [31:0] psc_word = merge({{(32-PSC_WIDTH){1'b0}}, prescaler_value}, avs_writedata,
		avs_byteenable);
	wire [31:0] ctl_word = merge({24'h000000, control_register_one}, avs_writedata,
		avs_byteenable);

	prescale_divider #(
		.WIDTH(PSC_WIDTH)
	) u_div (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.run(counter_enable_bit),
		.restart(wrap || update_generate),
		.load(any_update),
		.preload(prescaler_value),
		.active(prescale_active),
		.tick(tick)
	);

	count_core #(
		.WIDTH(CNT_WIDTH)
	) u_core (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.tick(tick),
		.down(down),
		.clear(update_generate),
		.limit(reload_active),
		.next_limit(reload_next),
		.write_en(wr && index == `ADDR_COUNT),
		.write_data(cnt_word[CNT_WIDTH-1:0]),
		.count(counter_value),
		.wrap(wrap)
	);

	// single-cycle wait keeps read data and write commit on one edge
	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= `RESET_WORD;
			avs_response <= 2'b00;
			ack <= 1'b0;
		end
		else
		begin
			ack <= req;
			avs_waitrequest <= !req;
			if (req)
			begin
				avs_response <= (index > `ADDR_PRESCALE_ACTIVE) ? 2'b10 : 2'b00;
				case (index)
					`ADDR_CONTROL: avs_readdata <= {24'h000000, control_register_one};
					`ADDR_STATUS: avs_readdata <= {31'h0, update_flag};
					`ADDR_COUNT: avs_readdata <= {{(32-CNT_WIDTH){1'b0}}, counter_value};
					`ADDR_PRESCALE: avs_readdata <= {{(32-PSC_WIDTH){1'b0}}, prescaler_value};
					`ADDR_RELOAD: avs_readdata <= {{(32-CNT_WIDTH){1'b0}}, auto_reload_value};
					`ADDR_RELOAD_ACTIVE: avs_readdata <= {{(32-CNT_WIDTH){1'b0}}, reload_active};
					`ADDR_PRESCALE_ACTIVE:
						avs_readdata <= {{(32-PSC_WIDTH){1'b0}}, prescale_active};
					default: avs_readdata <= `RESET_WORD;
				endcase
			end
		end
	end

	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			control_register_one <= 8'h00;
			update_flag <= 1'b0;
			prescaler_value <= `RESET_PRESCALE;
			auto_reload_value <= {CNT_WIDTH{1'b0}};
			reload_active <= {CNT_WIDTH{1'b0}};
			update_generate <= 1'b0;
			gen_quiet <= 1'b0;
			update_request <= 1'b0;
			update_event <= 1'b0;
		end
		else
		begin
			update_generate <= 1'b0;
			if (wr && index == `ADDR_CONTROL)
				control_register_one <= ctl_word[7:0];
			if (wr && index == `ADDR_PRESCALE)
				prescaler_value <= psc_word[PSC_WIDTH-1:0];
			if (wr && index == `ADDR_RELOAD)
				auto_reload_value <= arr_word[CNT_WIDTH-1:0];
			// lane 0 must be enabled, as for the status flag clear; other registers merge byte lanes
			if (wr && index == `ADDR_EVENT && avs_byteenable[0]
				&& avs_writedata[`BIT_UPDATE_GENERATE])
			begin
				update_generate <= 1'b1;
				gen_quiet <= update_request_select;
			end
			reload_active <= reload_next;
			// set beats a clear in the same cycle
			if (set_flag)
				update_flag <= 1'b1;
			else if (wr && index == `ADDR_STATUS && avs_byteenable[0]
				&& !avs_writedata[`BIT_UPDATE_FLAG])
				update_flag <= 1'b0;
			update_request <= set_flag;
			update_event <= any_update;
		end
	end
endmodule

/* File: hdl/prescale_divider.v */
/*
 prescaler divider: active ratio buffer plus divider counter.
 assumes caller pulses load on update events and restart on wraps.
*/
`include "timer_map.vh"
module prescale_divider #(
	parameter WIDTH = 16
) (
	input wire clk_sys,
	input wire sys_rst,
	input wire run,
	input wire restart,
	input wire load,
	input wire [WIDTH-1:0] preload,
	output reg [WIDTH-1:0] active,
	output wire tick
);
	reg [WIDTH-1:0] div_count;
	assign tick = run && (div_count == active);
	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			active <= `RESET_PRESCALE;
			div_count <= `RESET_PRESCALE;
		end
		else
		begin
			if (load)
				active <= preload;
			if (restart || tick)
				div_count <= {WIDTH{1'b0}};
			else if (run)
				div_count <= div_count + 1'b1;
		end
	end
endmodule

/* File: hdl/timer_map.vh */
/*
 time-base unit register map, field positions, reset values.
 assumes word-aligned avalon-mm byte addresses; 32-bit data.
*/
`ifndef TIMER_MAP_VH
`define TIMER_MAP_VH
`define ADDR_CONTROL 4'h0
`define ADDR_STATUS 4'h1
`define ADDR_EVENT 4'h2
`define ADDR_COUNT 4'h3
`define ADDR_PRESCALE 4'h4
`define ADDR_RELOAD 4'h5
`define ADDR_RELOAD_ACTIVE 4'h6
`define ADDR_PRESCALE_ACTIVE 4'h7
`define BIT_ENABLE 0
`define BIT_UPDATE_DISABLE 1
`define BIT_REQUEST_SELECT 2
`define BIT_DOWN 4
`define BIT_RELOAD_PRELOAD 7
`define BIT_UPDATE_FLAG 0
`define BIT_UPDATE_GENERATE 0
`define RESET_WORD 32'h0000_0000
`define RESET_PRESCALE 16'h0000
`endif
